// *** hdl/tcfoe_timer_ch1.v ***
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tcfoe_defines.vh"
module tcfoe_timer_ch1 (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire ded3_match_i,
  input wire gen4_event_i,
  input wire gen3_event_i,
  input wire ded3_xfer_start_i,
  input wire gen4_xfer_start_i,
  input wire gen3_xfer_start_i,
  input wire ded1_match_i,
  input wire ded2_match_i,
  input wire gen1_match_i,
  input wire gen2_match_i,
  input wire [1:0] gen1_edge_sel_i,
  input wire [1:0] gen2_edge_sel_i,
  output wire dedicated3_match_irq_o,
  output wire general4_event_irq_o,
  output wire general3_event_irq_o,
  output reg [3:0] cmp_out_o,
  output reg [3:0] cmp_out_en_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // next pin level for one output source
  function [1:0] oe_apply;
    input [1:0] code;
    input hit;
    input cur;
    begin
      oe_apply = {1'b0, cur};
      if (hit && code == `TCFOE_OE_LO)
        oe_apply = 2'b00;
      else if (hit && code == `TCFOE_OE_HI)
        oe_apply = 2'b01;
    end
  endfunction

  // source enabled: code 01 or 10 only
  function oe_on;
    input [1:0] code;
    begin
      oe_on = (code == `TCFOE_OE_LO) || (code == `TCFOE_OE_HI);
    end
  endfunction

  // zero-extend one register byte to the bus width
  function [31:0] rd_word;
    input [7:0] b;
    begin
      rd_word = {24'h00_0000, b};
    end
  endfunction

  // ----------------------------------------
  // state and bus decode
  // ----------------------------------------
  reg [2:0] flag_r;
  reg [2:0] flag_nxt;
  reg [2:0] armed_r;
  reg [2:0] armed_nxt;

  reg [7:0] out_en_a_r;
  reg [7:0] out_en_b_r;
  reg [2:0] irq_en_r;
  reg [31:0] rd_nxt;

  reg [3:0] pin_r;
  reg [3:0] pin_nxt;
  reg [3:0] pin_en_nxt;
  reg [1:0] n3;
  reg [1:0] n2;
  reg [1:0] n1;
  reg [1:0] n0;

  // a request counts once, in the cycle before ack
  wire req = cyc_i && stb_i && !ack_o;
  wire wr_lane0 = req && we_i && sel_i[0];
  wire rd_any = req && !we_i;
  wire hit_status = adr_i == `TCFOE_ADR_STATUS_B;
  wire hit_out_en_a = adr_i == `TCFOE_ADR_OUT_EN_A;
  wire hit_out_en_b = adr_i == `TCFOE_ADR_OUT_EN_B;
  wire hit_irq_en = adr_i == `TCFOE_ADR_IRQ_EN;
  wire rd_status = rd_any && hit_status;
  wire wr_status = wr_lane0 && hit_status;
  wire wr_out_en_a = wr_lane0 && hit_out_en_a;
  wire wr_out_en_b = wr_lane0 && hit_out_en_b;
  wire wr_irq_en = wr_lane0 && hit_irq_en;
  // events and transfer starts, in status bit order
  wire [2:0] set_ev = {ded3_match_i, gen4_event_i, gen3_event_i};
  wire [2:0] xfer_clr = {ded3_xfer_start_i, gen4_xfer_start_i, gen3_xfer_start_i};

  // ----------------------------------------
  // output enable and edge-select fields
  // ----------------------------------------
  // two bits per compare source
  wire ded2_out_hi_sel = out_en_a_r[7];
  wire ded2_out_lo_sel = out_en_a_r[6];
  wire ded1_out_hi_sel = out_en_a_r[5];
  wire ded1_out_lo_sel = out_en_a_r[4];
  wire gen2_out_hi_sel = out_en_a_r[3];
  wire gen2_out_lo_sel = out_en_a_r[2];
  wire gen1_out_hi_sel = out_en_a_r[1];
  wire gen1_out_lo_sel = out_en_a_r[0];
  wire [1:0] ded2_code = {ded2_out_hi_sel, ded2_out_lo_sel};
  wire [1:0] ded1_code = {ded1_out_hi_sel, ded1_out_lo_sel};
  wire [1:0] gen2_code = {gen2_out_hi_sel, gen2_out_lo_sel};
  wire [1:0] gen1_code = {gen1_out_hi_sel, gen1_out_lo_sel};

  // edge-select pairs of the two general registers
  wire gen2_edge_sel_hi = gen2_edge_sel_i[1];
  wire gen2_edge_sel_lo = gen2_edge_sel_i[0];
  wire gen1_edge_sel_hi = gen1_edge_sel_i[1];
  wire gen1_edge_sel_lo = gen1_edge_sel_i[0];
  // any nonzero pair turns the register into capture
  wire gen2_cap = gen2_edge_sel_hi || gen2_edge_sel_lo;
  wire gen1_cap = gen1_edge_sel_hi || gen1_edge_sel_lo;
  // a capture register never drives its pin on a match
  wire ded2_hit = ded2_match_i;
  wire ded1_hit = ded1_match_i;
  wire gen2_hit = gen2_match_i && !gen2_cap;
  wire gen1_hit = gen1_match_i && !gen1_cap;

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always @*
  begin
    flag_nxt = flag_r;
    armed_nxt = armed_r;
    if (rd_status)
      armed_nxt = armed_r | flag_r;
    // software clear needs a prior read of 1
    if (wr_status)
    begin
      flag_nxt = flag_r & ~(armed_r & ~dat_i[2:0]);
      armed_nxt = 3'b000;
    end
    flag_nxt = flag_nxt & ~xfer_clr;
    flag_nxt = flag_nxt | set_ev;
    armed_nxt = armed_nxt & flag_nxt;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      flag_r <= 3'b000;
    else if (ce_i)
      flag_r <= flag_nxt;
  end

  // arming remembers which flags software read as 1
  always @(posedge clk_i)
  begin
    if (rst_i)
      armed_r <= 3'b000;
    else if (ce_i)
      armed_r <= armed_nxt;
  end

  wire dedicated3_match_flag = flag_r[`TCFOE_BIT_DED3];
  wire general4_event_flag = flag_r[`TCFOE_BIT_GEN4];
  wire general3_event_flag = flag_r[`TCFOE_BIT_GEN3];
  wire ded3_irq_en = irq_en_r[`TCFOE_BIT_DED3];
  wire gen4_irq_en = irq_en_r[`TCFOE_BIT_GEN4];
  wire gen3_irq_en = irq_en_r[`TCFOE_BIT_GEN3];
  assign dedicated3_match_irq_o = dedicated3_match_flag && ded3_irq_en;
  assign general4_event_irq_o = general4_event_flag && gen4_irq_en;
  assign general3_event_irq_o = general3_event_flag && gen3_irq_en;

  // ----------------------------------------
  // registers and wishbone slave
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
      out_en_a_r <= `TCFOE_OUT_EN_RST;
    else if (ce_i && wr_out_en_a)
      out_en_a_r <= dat_i[7:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      out_en_b_r <= `TCFOE_OUT_EN_RST;
    else if (ce_i && wr_out_en_b)
      out_en_b_r <= dat_i[7:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      irq_en_r <= 3'b000;
    else if (ce_i && wr_irq_en)
      irq_en_r <= dat_i[2:0];
  end

  wire [7:0] status_byte = `TCFOE_STATUS_RSVD | {5'h00, flag_r};
  // 8-bit registers sit in the low byte
  always @*
  begin
    case (adr_i)
      `TCFOE_ADR_STATUS_B: rd_nxt = rd_word(status_byte);
      `TCFOE_ADR_OUT_EN_A: rd_nxt = rd_word(out_en_a_r);
      `TCFOE_ADR_OUT_EN_B: rd_nxt = rd_word(out_en_b_r);
      `TCFOE_ADR_IRQ_EN: rd_nxt = rd_word({5'h00, irq_en_r});
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // ack answers one cycle after the request is taken
  always @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else if (ce_i)
      ack_o <= req;
  end

  // read data stands until the next read
  always @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (ce_i && rd_any)
      dat_o <= rd_nxt;
  end

  // ----------------------------------------
  // compare match outputs
  // ----------------------------------------
  // index 3 ded2, 2 ded1, 1 gen2, 0 gen1
  always @*
  begin
    n3 = oe_apply(ded2_code, ded2_hit, pin_r[3]);
    n2 = oe_apply(ded1_code, ded1_hit, pin_r[2]);
    n1 = oe_apply(gen2_code, gen2_hit, pin_r[1]);
    n0 = oe_apply(gen1_code, gen1_hit, pin_r[0]);
    pin_nxt = {n3[0], n2[0], n1[0], n0[0]};
    pin_en_nxt[3] = oe_on(ded2_code);
    pin_en_nxt[2] = oe_on(ded1_code);
    pin_en_nxt[1] = oe_on(gen2_code) && !gen2_cap;
    pin_en_nxt[0] = oe_on(gen1_code) && !gen1_cap;
  end

  // last driven level is kept while a source is off
  always @(posedge clk_i)
  begin
    if (rst_i)
      pin_r <= 4'h0;
    else if (ce_i)
      pin_r <= pin_nxt;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      cmp_out_o <= 4'h0;
    else if (ce_i)
      cmp_out_o <= pin_nxt;
  end

  // enable follows the code, forced off in capture
  always @(posedge clk_i)
  begin
    if (rst_i)
      cmp_out_en_o <= 4'h0;
    else if (ce_i)
      cmp_out_en_o <= pin_en_nxt;
  end

endmodule // tcfoe_timer_ch1

// *** hdl/tcfoe_defines.vh ***
`ifndef TCFOE_DEFINES_VH
`define TCFOE_DEFINES_VH
// ----------------------------------------
// register word offsets (byte address)
// ----------------------------------------
`define TCFOE_ADR_STATUS_B 4'h0
`define TCFOE_ADR_OUT_EN_A 4'h4
`define TCFOE_ADR_OUT_EN_B 4'h8
`define TCFOE_ADR_IRQ_EN 4'hc
// ----------------------------------------
// status field positions and reset values
// ----------------------------------------
`define TCFOE_BIT_DED3 2
`define TCFOE_BIT_GEN4 1
`define TCFOE_BIT_GEN3 0
`define TCFOE_STATUS_RSVD 8'hf0
`define TCFOE_OUT_EN_RST 8'h00
`define TCFOE_IRQ_EN_RST 8'h00
// ----------------------------------------
// output enable codes
// ----------------------------------------
`define TCFOE_OE_OFF 2'b00
`define TCFOE_OE_LO 2'b01
`define TCFOE_OE_HI 2'b10
`endif

// *** verification/tcfoe_props.sv ***
`timescale 1ns/1ps
module tcfoe_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic ded2_match_i,
  input wire logic ded3_match_i,
  input wire logic gen4_event_i,
  input wire logic gen3_event_i,
  input wire logic dedicated3_match_irq_o,
  input wire logic ded3_xfer_start_i,
  input wire logic gen4_xfer_start_i,
  input wire logic gen3_xfer_start_i,
  input wire logic general4_event_irq_o,
  input wire logic general3_event_irq_o,
  input wire logic [1:0] gen1_edge_sel_i,
  input wire logic [3:0] cmp_out_o,
  input wire logic [3:0] cmp_out_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence take_s; cyc_i && stb_i && !ack_o && ce_i; endsequence
  sequence cap_s; ce_i && gen1_edge_sel_i != 2'h0 ##1 gen1_edge_sel_i != 2'h0; endsequence
  ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o) else $error("ack too long");
  ack_answer_a: assert property (take_s |=> ack_o) else $error("no ack");
  ded3_clear_a: assert property (ce_i && ded3_xfer_start_i && !ded3_match_i |=>
    !dedicated3_match_irq_o) else $error("ded3 flag kept");
  gen4_clear_a: assert property (ce_i && gen4_xfer_start_i && !gen4_event_i |=>
    !general4_event_irq_o) else $error("gen4 flag kept");
  gen3_clear_a: assert property (ce_i && gen3_xfer_start_i && !gen3_event_i |=>
    !general3_event_irq_o) else $error("gen3 flag kept");
  ded2_hold_a: assert property (ce_i && !ded2_match_i |=> $stable(cmp_out_o[3]))
    else $error("pin moved without match");
  gen1_cap_a: assert property (cap_s |-> !cmp_out_en_o[0]) else $error("capture drives");
  gen1_frozen_a: assert property (ce_i && gen1_edge_sel_i != 2'h0 |=>
    $stable(cmp_out_o[0])) else $error("capture pin moved");
endmodule // tcfoe_props
bind tcfoe_timer_ch1 tcfoe_props props_i (.*);

// *** verification/tcfoe_xfer_model.sv ***
`timescale 1ns/1ps
module tcfoe_xfer_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] irq_i,
  input wire logic [2:0] dly_i,
  output logic [2:0] start_o
);
  // answers a raised request after dly_i cycles with a one-cycle start
  initial
  begin
    start_o = 3'h0;
    forever
    begin
      @(posedge clk_i);
      if (!rst_i && irq_i != 3'h0)
      begin
        repeat (dly_i) @(posedge clk_i);
        start_o <= irq_i;
        @(posedge clk_i);
        start_o <= 3'h0;
      end
    end
  end
endmodule // tcfoe_xfer_model

// *** verification/timer_ch1_flags_output_enable_bench.sv ***
`timescale 1ns/1ps
module timer_ch1_flags_output_enable_bench;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [3:0] adr_i = 0, sel_i = 4'hf, cmp_out_o, cmp_out_en_o, pin = 0;
  logic [31:0] dat_i = 0, dat_o, q, v, seed = 32'h0bf2;
  logic [1:0] gen1_edge_sel_i = 0, gen2_edge_sel_i = 0, c;
  logic [6:0] ev = 0;
  logic [2:0] dly = 0, st, irq;
  wire ded3_match_i, gen4_event_i, gen3_event_i, ded1_match_i, ded2_match_i, gen1_match_i;
  wire gen2_match_i, ded3_xfer_start_i, gen4_xfer_start_i, gen3_xfer_start_i;
  wire dedicated3_match_irq_o, general4_event_irq_o, general3_event_irq_o;
  int n_errors = 0, comparisons = 0;
  assign {ded2_match_i, ded1_match_i, gen2_match_i, gen1_match_i} = ev[6:3];
  assign {ded3_match_i, gen4_event_i, gen3_event_i} = ev[2:0];
  assign {ded3_xfer_start_i, gen4_xfer_start_i, gen3_xfer_start_i} = st;
  assign irq = {dedicated3_match_irq_o, general4_event_irq_o, general3_event_irq_o};
  tcfoe_timer_ch1 uut (.*);
  tcfoe_xfer_model data_transfer_controller (.clk_i, .rst_i, .irq_i(irq), .dly_i(dly), .start_o(st));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic pin_nxt(input logic [1:0] cd, input logic p);
    return cd == 2'h1 ? 1'b0 : cd == 2'h2 ? 1'b1 : p;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic pls(input int b);
    @(posedge clk_i);
    ev[b] <= 1'b1;
    @(posedge clk_i);
    ev[b] <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #5 clk_i = ~clk_i;
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 4'h0, 0); chk(q, 32'h0000_00f0);
    bus(0, 4'h4, 0); chk(q, 0);
    v = rnd();
    bus(1, 4'h4, v); bus(0, 4'h4, 0); chk(q, {24'h0, v[7:0]});
    bus(1, 4'h1, v); bus(0, 4'h1, 0); chk(q, 0);
    bus(1, 4'h8, ~v);
    bus(0, 4'h8, 0);
    chk(q, {24'h0, ~v[7:0]});
    for (int b = 0; b < 3; b++)
    begin
      pls(b);
      bus(0, 4'h0, 0); chk(q[b], 1);
      fork bus(1, 4'h0, 0); pls(b); join
      bus(0, 4'h0, 0); chk(q[b], 1);
      bus(1, 4'h0, 0);
      bus(0, 4'h0, 0); chk(q, 32'h0000_00f0);
    end
    bus(1, 4'hc, 32'h0000_0007);
    for (int b = 0; b < 3; b++)
    begin
      v = rnd();
      dly <= v[2:0];
      pls(b);
      @(negedge clk_i); chk(irq[b], 1);
      repeat (12) @(posedge clk_i);
      chk(irq[b], 0);
    end
    bus(0, 4'hc, 0);
    chk(q, 32'h0000_0007);
    bus(1, 4'hc, 0);
    ce_i <= 0;
    pls(0);
    @(posedge clk_i);
    ce_i <= 1;
    bus(0, 4'h0, 0);
    chk(q, 32'h0000_00f0);
    for (int k = 0; k < 4; k++)
      for (int j = 0; j < 4; j++)
      begin
        c = 2'(j + 2);
        bus(1, 4'h4, 32'(c) << 2 * k);
        pls(3 + k);
        @(negedge clk_i);
        pin[k] = pin_nxt(c, pin[k]);
        chk({pe_k(k), cmp_out_o[k]}, {c == 2'h1 || c == 2'h2, pin[k]});
      end
    v = rnd();
    @(posedge clk_i);
    {gen1_edge_sel_i, gen2_edge_sel_i} <= {2{v[1:0] | 2'h1}};
    bus(1, 4'h4, 32'h0000_000a);
    pls(3);
    pls(4);
    @(negedge clk_i);
    chk({cmp_out_en_o[1:0], cmp_out_o[1:0]}, {2'h0, pin[1:0]});
    bus(1, 4'h4, 32'h0000_0055);
    @(posedge clk_i);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 4'h4, 0);
    chk(q, 0);
    chk(cmp_out_en_o, 0);
    print_verdict();
  end
  function automatic logic pe_k(input int k);
    return cmp_out_en_o[k];
  endfunction
endmodule // timer_ch1_flags_output_enable_bench
